// File: hw/lpmc_pkg.sv
package lpmc_pkg;

  // operating modes of the application side and of the effective state
  typedef enum logic [2:0] {
    M_RUN      = 3'h0,
    M_SLEEP    = 3'h1,
    M_LPRUN    = 3'h2,
    M_LPSLEEP  = 3'h3,
    M_STOP0    = 3'h4,
    M_STOP1    = 3'h5,
    M_STANDBY  = 3'h6,
    M_SHUTDOWN = 3'h7
  } lpmc_mode_t;

  // system clock choice after a wakeup
  typedef enum logic [1:0] {
    CLK_MSI   = 2'h0,
    CLK_INTERNAL_HIGH_SPEED_RC = 2'h1,
    CLK_MSI4  = 2'h2
  } lpmc_clk_t;

  // wakeup and event sources, all one-cycle or level inputs
  typedef struct packed {
    logic ext_rst;
    logic independent_watchdog;
    logic rtc;
    logic lse_fail;
    logic periph;
    logic irq;
  } lpmc_wake_t;

  // clock figures in MHz, retained SRAM size in KB
  localparam int LPRUN_CPU_MHZ = 2;
  localparam int STOP_MSI_MAX_MHZ = 48;
  localparam int STANDBY_WAKE_MHZ = 16;
  localparam int SHUTDOWN_WAKE_MHZ = 4;
  localparam int RETAIN_SRAM_KB = 48;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WAKE_OFS = 8'h04;
  localparam logic [7:0] IOCFG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] OPT_OFS = 8'h10;

  // control field positions
  localparam int C_MODE = 0;
  localparam int C_PVD_EN = 3;
  localparam int C_PVD_FALL_IE = 4;
  localparam int C_PVD_RISE_IE = 5;
  localparam int C_STEP_DOWN_CONVERTER_ON = 6;
  localparam int C_STEP_DOWN_CONVERTER_AUTO = 7;
  localparam int C_SRAM_RET = 8;
  localparam int C_STOP_HSI = 9;
  localparam int CTRL_W = 10;

  // status flag positions that clear on a written one
  localparam int S_PVD_FALL = 8;
  localparam int S_PVD_RISE = 9;

  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [2:0] BOR_LVL_RST = 3'h0;

endpackage

// File: hw/lpmc_top.sv
`timescale 1ns/1ps
// What this block does
// [R1] main regulator feeds core in run, sleep and fast stop
// [R2] low-power regulator in low-power run/sleep, second stop, retained standby
// [R3] standby and shutdown: main regulator off, core unpowered; low-power regulator stays on only in retained standby
// [R4] low-power run: main regulator off, processor clock 2 MHz, radio off
// [R5] brown-out reset held while supply low, active except in shutdown
// [R6] brown-out threshold starts lowest, raised only by option setting
// [R7] enabled supply detector interrupts on falling, rising or both
// [R8] analog supply monitor reports analog supply within range
// [R9] enabled, converter forced to bypass below option-chosen level
// [R10] reset starts in run; low-power mode only on software choice
// [R11] sleep halts processor only; any interrupt wakes it
// [R12] low-power sleep only from low-power run, returns there, radio off
// [R13] stop modes retain memory and registers; first keeps main regulator
// [R14] wakeup peripherals may enable the fast RC in stop
// [R15] stop exit clock multispeed or fast RC; fast RC if radio used
// [R16] standby pins take software-chosen pull-up, pull-down or float
// [R17] standby clears registers; SRAM kept only with retention chosen
// [R18] standby left on reset pin, watchdog, pin edge, clock, crystal fail
// [R19] standby wakes on 16 MHz RC; refused while radio active
// [R20] shutdown: no brown-out; left on reset pin, pin edge, clock event
// [R21] shutdown wakes on 4 MHz multispeed oscillator
// [R22] effective state is the higher of processor and radio requests
// [R23] converter starts in bypass until software switches it on
// [R24] rank: run, first stop, second stop, standby, shutdown
// [R25] per wakeup pin polarity bit picks rising or falling edge
module lpmc_top #(
  parameter int N_WKP = 2,
  parameter int N_IO = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire lpmc_pkg::lpmc_mode_t radio_req_i,
  input wire logic radio_active_i,
  input wire lpmc_pkg::lpmc_wake_t wake_i,
  input wire logic [N_WKP-1:0] wakeup_pin_i,
  input wire logic vdd_below_bor_i,
  input wire logic vdd_below_pvd_i,
  input wire logic vdda_ok_i,
  input wire logic vdd_below_step_down_converter_lvl_i,
  input wire logic opt_valid_i,
  input wire logic [2:0] opt_bor_level_i,
  input wire logic [2:0] opt_step_down_converter_level_i,
  input wire logic periph_hsi_req_i,
  output logic main_core_regulator_en_o,
  output logic low_power_core_regulator_en_o,
  output logic core_logic_supply_on_o,
  output logic brown_out_detector_en_o,
  output logic brown_out_reset_o,
  output logic [2:0] bor_level_o,
  output logic [2:0] step_down_converter_bypass_level_o,
  output logic step_down_converter_bypass_o,
  output logic pvd_irq_o,
  output logic pvm_ok_o,
  output logic cpu_halt_o,
  output logic cpu_clk_2mhz_limit_o,
  output logic radio_en_o,
  output logic hsi_enable_o,
  output logic retain_o,
  output logic sram_retain_o,
  output lpmc_pkg::lpmc_mode_t eff_mode_o,
  output lpmc_pkg::lpmc_clk_t sysclk_sel_o,
  output logic [2*N_IO-1:0] io_pull_o
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    lpmc_pkg::lpmc_mode_t mode;
    lpmc_pkg::lpmc_mode_t eff;
    logic [lpmc_pkg::CTRL_W-1:0] ctrl;
    logic [N_WKP-1:0] pol;
    logic [N_WKP-1:0] pin_prev;
    logic [2*N_IO-1:0] iocfg;
    logic [2:0] bor_lvl;
    logic [2:0] step_down_converter_lvl;
    logic pvd_prev;
    logic pvd_fall;
    logic pvd_rise;
    logic woke_stby;
    logic woke_shdn;
    lpmc_pkg::lpmc_clk_t clk;
    logic main_en;
    logic lp_en;
    logic core_on;
    logic bor_en;
    logic bor_rst;
    logic bypass;
    logic irq;
    logic analog_supply_monitor;
    logic halt;
    logic lim;
    logic radio;
    logic hsi;
    logic ret;
    logic sram;
    logic [2*N_IO-1:0] io;
  } lpmc_state_t;

  lpmc_state_t s_reg;
  lpmc_state_t s_next;

  // rank of a mode, higher keeps more of the chip alive
  function automatic logic [2:0] rank(input lpmc_pkg::lpmc_mode_t m);
    case (m)
      lpmc_pkg::M_STOP0: rank = 3'h3;
      lpmc_pkg::M_STOP1: rank = 3'h2;
      lpmc_pkg::M_STANDBY: rank = 3'h1;
      lpmc_pkg::M_SHUTDOWN: rank = 3'h0;
      default: rank = 3'h4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic req;
  logic wr;
  logic [N_WKP-1:0] pin_edge;
  logic pin_wake;
  logic stop_wake;
  logic stby_wake;
  logic shdn_wake;
  logic mode_ok;
  lpmc_pkg::lpmc_mode_t wmode;
  lpmc_pkg::lpmc_mode_t eff;

  always_comb begin
    s_next = s_reg;
    req = wb_cyc_i & wb_stb_i;
    // write takes effect on the edge where ack is seen high
    wr = req & wb_we_i & s_reg.ack & wb_sel_i[0];
    wmode = lpmc_pkg::lpmc_mode_t'(wb_dat_i[lpmc_pkg::C_MODE +: 3]);

    // bus ack pulse and read data
    s_next.ack = req & ~s_reg.ack;
    s_next.dat = 32'h0000_0000;
    if (req & ~s_reg.ack & ~wb_we_i) begin
      case (wb_adr_i)
        lpmc_pkg::CTRL_OFS: s_next.dat = 32'(s_reg.ctrl);
        lpmc_pkg::WAKE_OFS: s_next.dat = 32'(s_reg.pol);
        lpmc_pkg::IOCFG_OFS: s_next.dat = 32'(s_reg.iocfg);
        lpmc_pkg::STAT_OFS: s_next.dat = {18'h0_0000, s_reg.woke_shdn,
          s_reg.woke_stby, s_reg.bor_rst, s_reg.bypass, s_reg.pvd_rise,
          s_reg.pvd_fall, s_reg.analog_supply_monitor, s_reg.pvd_prev, s_reg.eff,
          s_reg.mode};
        lpmc_pkg::OPT_OFS: s_next.dat = {26'h000_0000, s_reg.step_down_converter_lvl,
          s_reg.bor_lvl};
        default: s_next.dat = 32'h0000_0000;
      endcase
    end

    // [R25] edge of chosen polarity
    s_next.pin_prev = wakeup_pin_i;
    pin_edge = (wakeup_pin_i & ~s_reg.pin_prev & ~s_reg.pol) |
               (~wakeup_pin_i & s_reg.pin_prev & s_reg.pol);
    pin_wake = |pin_edge;
    stop_wake = wake_i.periph | wake_i.rtc | wake_i.irq | pin_wake;
    // [R18] standby exit sources
    stby_wake = wake_i.ext_rst | wake_i.independent_watchdog | pin_wake | wake_i.rtc |
                wake_i.lse_fail;
    // [R20] shutdown exit sources
    shdn_wake = wake_i.ext_rst | pin_wake | wake_i.rtc;

    // register writes
    if (wr & (wb_adr_i == lpmc_pkg::CTRL_OFS)) begin
      // [R12] low-power sleep only from low-power run
      case (wmode)
        lpmc_pkg::M_LPSLEEP: mode_ok = (s_reg.mode == lpmc_pkg::M_LPRUN);
        // [R19] no standby or shutdown while radio busy
        lpmc_pkg::M_STANDBY: mode_ok = ~radio_active_i;
        lpmc_pkg::M_SHUTDOWN: mode_ok = ~radio_active_i;
        default: mode_ok = 1'b1;
      endcase
      s_next.ctrl[lpmc_pkg::CTRL_W-1:3] = wb_dat_i[lpmc_pkg::CTRL_W-1:3];
      // [R10] low-power mode entered only by software
      if (mode_ok) begin
        s_next.mode = wmode;
        s_next.ctrl[2:0] = wb_dat_i[2:0];
      end
    end else begin
      mode_ok = 1'b0;
    end
    if (wr & (wb_adr_i == lpmc_pkg::WAKE_OFS)) begin
      s_next.pol = wb_dat_i[N_WKP-1:0];
    end
    if (wr & (wb_adr_i == lpmc_pkg::IOCFG_OFS)) begin
      s_next.iocfg = wb_dat_i[2*N_IO-1:0];
    end

    // [R7] sticky detector flags, set wins over clear
    if (wr & (wb_adr_i == lpmc_pkg::STAT_OFS)) begin
      if (wb_dat_i[lpmc_pkg::S_PVD_FALL]) begin
        s_next.pvd_fall = 1'b0;
      end
      if (wb_dat_i[lpmc_pkg::S_PVD_RISE]) begin
        s_next.pvd_rise = 1'b0;
      end
    end
    s_next.pvd_prev = vdd_below_pvd_i;
    if (s_reg.ctrl[lpmc_pkg::C_PVD_EN]) begin
      if (vdd_below_pvd_i & ~s_reg.pvd_prev) begin
        s_next.pvd_fall = 1'b1;
      end
      if (~vdd_below_pvd_i & s_reg.pvd_prev) begin
        s_next.pvd_rise = 1'b1;
      end
    end
    s_next.irq = (s_next.pvd_fall & s_next.ctrl[lpmc_pkg::C_PVD_FALL_IE]) |
                 (s_next.pvd_rise & s_next.ctrl[lpmc_pkg::C_PVD_RISE_IE]);

    // [R6] thresholds move only from the option load
    if (opt_valid_i) begin
      s_next.bor_lvl = opt_bor_level_i;
      s_next.step_down_converter_lvl = opt_step_down_converter_level_i;
    end

    // wakeup handling per mode
    if (!mode_ok) begin
      case (s_reg.mode)
        // [R11] any interrupt wakes the processor
        lpmc_pkg::M_SLEEP: begin
          if (wake_i.irq) begin
            s_next.mode = lpmc_pkg::M_RUN;
          end
        end
        // [R12] back to low-power run
        lpmc_pkg::M_LPSLEEP: begin
          if (wake_i.irq) begin
            s_next.mode = lpmc_pkg::M_LPRUN;
          end
        end
        lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1: begin
          if (stop_wake) begin
            s_next.mode = lpmc_pkg::M_RUN;
            // [R15] radio in use forces fast RC
            s_next.clk = (s_reg.ctrl[lpmc_pkg::C_STOP_HSI] | radio_active_i)
                         ? lpmc_pkg::CLK_INTERNAL_HIGH_SPEED_RC : lpmc_pkg::CLK_MSI;
          end
        end
        lpmc_pkg::M_STANDBY: begin
          if (stby_wake) begin
            s_next.mode = lpmc_pkg::M_RUN;
            // [R19] wake on 16 MHz RC
            s_next.clk = lpmc_pkg::CLK_INTERNAL_HIGH_SPEED_RC;
            // [R17] core registers lost; pin setup survives
            s_next.ctrl = lpmc_pkg::CTRL_RST;
            s_next.woke_stby = 1'b1;
          end
        end
        lpmc_pkg::M_SHUTDOWN: begin
          if (shdn_wake) begin
            s_next.mode = lpmc_pkg::M_RUN;
            // [R21] wake on 4 MHz multispeed
            s_next.clk = lpmc_pkg::CLK_MSI4;
            s_next.ctrl = lpmc_pkg::CTRL_RST;
            s_next.woke_shdn = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (mode_ok) begin
      s_next.woke_stby = 1'b0;
      s_next.woke_shdn = 1'b0;
    end

    // [R22] [R24] effective state is the higher ranked request
    if ((s_next.mode == lpmc_pkg::M_LPRUN) |
        (s_next.mode == lpmc_pkg::M_LPSLEEP) |
        (rank(s_next.mode) >= rank(radio_req_i))) begin
      eff = s_next.mode;
    end else begin
      eff = radio_req_i;
    end
    s_next.eff = eff;

    // [R1] main regulator
    s_next.main_en = (eff == lpmc_pkg::M_RUN) | (eff == lpmc_pkg::M_SLEEP) |
                     (eff == lpmc_pkg::M_STOP0);
    // [R2] low-power regulator, incl. retained standby
    s_next.lp_en = (eff == lpmc_pkg::M_LPRUN) |
                   (eff == lpmc_pkg::M_LPSLEEP) |
                   (eff == lpmc_pkg::M_STOP1) |
                   ((eff == lpmc_pkg::M_STANDBY) &
                    s_next.ctrl[lpmc_pkg::C_SRAM_RET]);
    // [R3] core unpowered in standby and shutdown
    s_next.core_on = (eff != lpmc_pkg::M_STANDBY) &
                     (eff != lpmc_pkg::M_SHUTDOWN);
    // [R17] SRAM kept only with retention chosen
    s_next.sram = s_next.core_on | ((eff == lpmc_pkg::M_STANDBY) &
                  s_next.ctrl[lpmc_pkg::C_SRAM_RET]);
    // [R13] stop modes retain contents
    s_next.ret = (eff == lpmc_pkg::M_STOP0) | (eff == lpmc_pkg::M_STOP1);
    // [R14] wakeup peripherals may run the fast RC
    s_next.hsi = s_next.ret & periph_hsi_req_i;

    // [R5] [R20] brown-out off only in shutdown
    s_next.bor_en = (eff != lpmc_pkg::M_SHUTDOWN);
    s_next.bor_rst = s_next.bor_en & vdd_below_bor_i;

    // [R23] bypass until software turns converter on
    // [R9] forced bypass below option level
    s_next.bypass = ~s_next.ctrl[lpmc_pkg::C_STEP_DOWN_CONVERTER_ON] |
                    (s_next.ctrl[lpmc_pkg::C_STEP_DOWN_CONVERTER_AUTO] &
                     vdd_below_step_down_converter_lvl_i);

    // [R8] analog supply monitor
    s_next.analog_supply_monitor = vdda_ok_i;

    // [R11] [R12] processor halted outside running modes
    s_next.halt = (s_next.mode != lpmc_pkg::M_RUN) &
                  (s_next.mode != lpmc_pkg::M_LPRUN);
    // [R4] low-power run: 2 MHz limit, radio off
    s_next.lim = (eff == lpmc_pkg::M_LPRUN) | (eff == lpmc_pkg::M_LPSLEEP);
    s_next.radio = s_next.core_on & ~s_next.lim;

    // [R16] standby pin pulls
    s_next.io = (eff == lpmc_pkg::M_STANDBY) ? s_next.iocfg
                : {2*N_IO{1'b0}};
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      // [R10] run after reset
      s_reg.mode <= lpmc_pkg::M_RUN;
      s_reg.eff <= lpmc_pkg::M_RUN;
      s_reg.ctrl <= lpmc_pkg::CTRL_RST;
      // [R6] lowest threshold at power-on
      s_reg.bor_lvl <= lpmc_pkg::BOR_LVL_RST;
      s_reg.clk <= lpmc_pkg::CLK_MSI;
      s_reg.main_en <= 1'b1;
      s_reg.core_on <= 1'b1;
      s_reg.bor_en <= 1'b1;
      s_reg.bypass <= 1'b1;
      s_reg.radio <= 1'b1;
      s_reg.sram <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign main_core_regulator_en_o = s_reg.main_en;
  assign low_power_core_regulator_en_o = s_reg.lp_en;
  assign core_logic_supply_on_o = s_reg.core_on;
  assign brown_out_detector_en_o = s_reg.bor_en;
  assign brown_out_reset_o = s_reg.bor_rst;
  assign bor_level_o = s_reg.bor_lvl;
  assign step_down_converter_bypass_level_o = s_reg.step_down_converter_lvl;
  assign step_down_converter_bypass_o = s_reg.bypass;
  assign pvd_irq_o = s_reg.irq;
  assign pvm_ok_o = s_reg.analog_supply_monitor;
  assign cpu_halt_o = s_reg.halt;
  assign cpu_clk_2mhz_limit_o = s_reg.lim;
  assign radio_en_o = s_reg.radio;
  assign hsi_enable_o = s_reg.hsi;
  assign retain_o = s_reg.ret;
  assign sram_retain_o = s_reg.sram;
  assign eff_mode_o = s_reg.eff;
  assign sysclk_sel_o = s_reg.clk;
  assign io_pull_o = s_reg.io;

endmodule // lpmc_top

// File: testbench/lpmc_radio_model.sv
`timescale 1ns/1ps
// radio side: asks for a power state and says when it is busy
module lpmc_radio_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lpmc_pkg::lpmc_mode_t want_i,
  input wire logic busy_i,
  output lpmc_pkg::lpmc_mode_t radio_req_o,
  output logic radio_active_o
);
  // request follows the commanded state one edge later
  // busy flag blocks standby on the far side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      radio_req_o <= lpmc_pkg::M_SHUTDOWN;
      radio_active_o <= 1'b0;
    end else begin
      radio_req_o <= want_i;
      radio_active_o <= busy_i;
    end
  end
endmodule // lpmc_radio_model

// File: testbench/lpmc_chk_sva.sv
`timescale 1ns/1ps
// port-level checks of the power-state controller
module lpmc_chk #(
  parameter int N_IO = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic vdd_below_bor_i,
  input wire logic main_core_regulator_en_o,
  input wire logic low_power_core_regulator_en_o,
  input wire logic core_logic_supply_on_o,
  input wire logic brown_out_detector_en_o,
  input wire logic brown_out_reset_o,
  input wire logic step_down_converter_bypass_o,
  input wire logic pvd_irq_o,
  input wire logic cpu_halt_o,
  input wire logic cpu_clk_2mhz_limit_o,
  input wire logic radio_en_o,
  input wire lpmc_pkg::lpmc_mode_t eff_mode_o,
  input wire logic [2*N_IO-1:0] io_pull_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // short aliases
  wire lpmc_pkg::lpmc_mode_t m = eff_mode_o;
  wire mr = main_core_regulator_en_o;
  wire bor_en = brown_out_detector_en_o;
  // regulator choice per effective mode
  mr_modes_a: assert property (
    m inside {lpmc_pkg::M_RUN, lpmc_pkg::M_SLEEP, lpmc_pkg::M_STOP0} |-> mr)
    else $error("main regulator off");
  lpr_modes_a: assert property (
    m inside {lpmc_pkg::M_LPRUN, lpmc_pkg::M_LPSLEEP, lpmc_pkg::M_STOP1}
    |-> low_power_core_regulator_en_o && !mr) else $error("wrong regulator");
  core_off_a: assert property (
    m inside {lpmc_pkg::M_STANDBY, lpmc_pkg::M_SHUTDOWN}
    |-> !mr && !core_logic_supply_on_o) else $error("core still powered");
  lprun_limit_a: assert property (
    m == lpmc_pkg::M_LPRUN |-> cpu_clk_2mhz_limit_o && !radio_en_o)
    else $error("low-power run limits missing");
  // supervision
  bor_hold_a: assert property (
    vdd_below_bor_i && bor_en ##1 bor_en |-> brown_out_reset_o)
    else $error("brown-out reset not held");
  bor_off_a: assert property (
    m == lpmc_pkg::M_SHUTDOWN |-> !bor_en) else $error("brown-out on");
  sleep_halt_a: assert property (
    m == lpmc_pkg::M_SLEEP |-> cpu_halt_o && radio_en_o)
    else $error("sleep state wrong");
  io_idle_a: assert property (
    m != lpmc_pkg::M_STANDBY |-> io_pull_o == '0)
    else $error("pin pulls outside standby");
  reset_run_a: assert property (
    $fell(rst_i) |-> m == lpmc_pkg::M_RUN && step_down_converter_bypass_o)
    else $error("reset state wrong");
  // main scenarios reached
  cover property (m == lpmc_pkg::M_SLEEP);
  cover property (m == lpmc_pkg::M_STANDBY);
  cover property ($rose(pvd_irq_o));
endmodule // lpmc_chk

bind lpmc_top lpmc_chk #(.N_IO(N_IO)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .vdd_below_bor_i(vdd_below_bor_i), .pvd_irq_o(pvd_irq_o),
  .main_core_regulator_en_o(main_core_regulator_en_o),
  .low_power_core_regulator_en_o(low_power_core_regulator_en_o),
  .core_logic_supply_on_o(core_logic_supply_on_o),
  .brown_out_detector_en_o(brown_out_detector_en_o),
  .brown_out_reset_o(brown_out_reset_o), .cpu_halt_o(cpu_halt_o),
  .step_down_converter_bypass_o(step_down_converter_bypass_o),
  .cpu_clk_2mhz_limit_o(cpu_clk_2mhz_limit_o), .radio_en_o(radio_en_o),
  .eff_mode_o(eff_mode_o), .io_pull_o(io_pull_o));

// File: testbench/tb.sv
`timescale 1ns/1ps
// self-checking bench for the power-state controller
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  lpmc_pkg::lpmc_mode_t radio_req_i, want, eff_mode_o;
  lpmc_pkg::lpmc_wake_t wake_i;
  lpmc_pkg::lpmc_clk_t sysclk_sel_o;
  logic [1:0] wakeup_pin_i;
  logic [2:0] opt_bor_level_i, opt_step_down_converter_level_i;
  logic [2:0] bor_level_o, step_down_converter_bypass_level_o;
  logic [15:0] io_pull_o;
  logic radio_active_i, busy, vdd_below_bor_i, vdd_below_pvd_i, vdda_ok_i;
  logic vdd_below_step_down_converter_lvl_i, opt_valid_i, periph_hsi_req_i, pvm_ok_o;
  logic main_core_regulator_en_o, low_power_core_regulator_en_o;
  logic core_logic_supply_on_o, brown_out_detector_en_o, brown_out_reset_o;
  logic step_down_converter_bypass_o, pvd_irq_o, cpu_halt_o, retain_o;
  logic cpu_clk_2mhz_limit_o, radio_en_o, hsi_enable_o, sram_retain_o;
  int n_fail, check_count, tick;

  lpmc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .radio_req_i, .radio_active_i,
    .wake_i, .wakeup_pin_i, .vdd_below_bor_i, .vdd_below_pvd_i, .vdda_ok_i,
    .vdd_below_step_down_converter_lvl_i, .opt_valid_i, .opt_bor_level_i, .opt_step_down_converter_level_i,
    .periph_hsi_req_i, .main_core_regulator_en_o, .core_logic_supply_on_o,
    .low_power_core_regulator_en_o, .brown_out_detector_en_o, .bor_level_o,
    .brown_out_reset_o, .step_down_converter_bypass_level_o, .step_down_converter_bypass_o,
    .pvd_irq_o, .pvm_ok_o, .cpu_halt_o, .cpu_clk_2mhz_limit_o, .radio_en_o,
    .hsi_enable_o, .retain_o, .sram_retain_o, .eff_mode_o, .sysclk_sel_o,
    .io_pull_o);
  lpmc_radio_model rm (.clk_i, .rst_i, .want_i(want), .busy_i(busy),
    .radio_req_o(radio_req_i), .radio_active_o(radio_active_i));

  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    tick++;
    if (tick == 5000) begin
      n_fail++;
      close_out;
    end
  end

  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic bus cycle, waits for ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) ck("ack", 1, 0);
  endtask

  // write a mode plus control bits, then check the effective mode
  task go(input lpmc_pkg::lpmc_mode_t m, input logic [31:0] x,
    input lpmc_pkg::lpmc_mode_t e);
    wb(1'b1, lpmc_pkg::CTRL_OFS, x | {29'h0, m});
    tk(3);
    ck("eff", e, eff_mode_o);
  endtask

  task pulse(input logic [5:0] v, input lpmc_pkg::lpmc_mode_t e);
    @(posedge clk_i);
    wake_i <= v;
    @(posedge clk_i);
    wake_i <= '0;
    tk(3);
    ck("eff", e, eff_mode_o);
  endtask

  task t_reset;
    ck("eff", lpmc_pkg::M_RUN, eff_mode_o);
    ck("bypass", 1, step_down_converter_bypass_o);
    ck("bor_level", 0, bor_level_o);
    wb(1'b0, 8'h20, 32'h0);
    ck("unmapped", 0, rd);
  endtask

  task t_sleep;
    go(lpmc_pkg::M_SLEEP, 0, lpmc_pkg::M_SLEEP);
    ck("halt", 1, cpu_halt_o);
    pulse(6'h01, lpmc_pkg::M_RUN);
    go(lpmc_pkg::M_LPSLEEP, 0, lpmc_pkg::M_RUN);
    go(lpmc_pkg::M_LPRUN, 0, lpmc_pkg::M_LPRUN);
    ck("lp_reg", 1, low_power_core_regulator_en_o);
    ck("radio", 0, radio_en_o);
    go(lpmc_pkg::M_LPSLEEP, 0, lpmc_pkg::M_LPSLEEP);
    pulse(6'h01, lpmc_pkg::M_LPRUN);
    go(lpmc_pkg::M_RUN, 0, lpmc_pkg::M_RUN);
  endtask

  task t_stop;
    busy <= 1'b1;
    go(lpmc_pkg::M_STOP0, 0, lpmc_pkg::M_STOP0);
    ck("retain", 1, retain_o);
    periph_hsi_req_i <= 1'b1;
    tk(3);
    ck("hsi_en", 1, hsi_enable_o);
    periph_hsi_req_i <= 1'b0;
    pulse(6'h02, lpmc_pkg::M_RUN);
    ck("clk", lpmc_pkg::CLK_INTERNAL_HIGH_SPEED_RC, sysclk_sel_o);
    busy <= 1'b0;
    go(lpmc_pkg::M_STOP1, 0, lpmc_pkg::M_STOP1);
    want <= lpmc_pkg::M_STOP0;
    tk(3);
    ck("eff", lpmc_pkg::M_STOP0, eff_mode_o);
    want <= lpmc_pkg::M_STANDBY;
    tk(3);
    ck("eff", lpmc_pkg::M_STOP1, eff_mode_o);
    want <= lpmc_pkg::M_SHUTDOWN;
    pulse(6'h08, lpmc_pkg::M_RUN);
    ck("clk", lpmc_pkg::CLK_MSI, sysclk_sel_o);
  endtask

  task t_standby;
    busy <= 1'b1;
    go(lpmc_pkg::M_STANDBY, 0, lpmc_pkg::M_RUN);
    busy <= 1'b0;
    wb(1'b1, lpmc_pkg::IOCFG_OFS, 32'h0000a5c3);
    go(lpmc_pkg::M_STANDBY, 32'h100, lpmc_pkg::M_STANDBY);
    ck("bor_en", 1, brown_out_detector_en_o);
    ck("io_pull", 32'h0000a5c3, io_pull_o);
    ck("sram", 1, sram_retain_o);
    ck("lp_reg", 1, low_power_core_regulator_en_o);
    wakeup_pin_i <= 2'b01;
    tk(3);
    ck("eff", lpmc_pkg::M_RUN, eff_mode_o);
    ck("clk", lpmc_pkg::CLK_INTERNAL_HIGH_SPEED_RC, sysclk_sel_o);
    wb(1'b0, lpmc_pkg::CTRL_OFS, 32'h0);
    ck("ctrl", 0, rd);
    go(lpmc_pkg::M_SHUTDOWN, 0, lpmc_pkg::M_SHUTDOWN);
    pulse(6'h10, lpmc_pkg::M_SHUTDOWN);
    pulse(6'h08, lpmc_pkg::M_RUN);
    ck("clk", lpmc_pkg::CLK_MSI4, sysclk_sel_o);
    // falling edge on pin 0 wakes once its polarity bit is set
    wb(1'b1, lpmc_pkg::WAKE_OFS, 32'h1);
    go(lpmc_pkg::M_SHUTDOWN, 0, lpmc_pkg::M_SHUTDOWN);
    wakeup_pin_i <= 2'b00;
    tk(3);
    ck("eff", lpmc_pkg::M_RUN, eff_mode_o);
  endtask

  task t_supply;
    vdd_below_bor_i <= 1'b1;
    opt_bor_level_i <= 3'h5;
    opt_step_down_converter_level_i <= 3'h3;
    opt_valid_i <= 1'b1;
    vdda_ok_i <= 1'b0;
    tk(3);
    ck("bor_rst", 1, brown_out_reset_o);
    ck("bor_level", 5, bor_level_o);
    ck("step_down_converter_level", 3, step_down_converter_bypass_level_o);
    ck("pvm", 0, pvm_ok_o);
    vdd_below_bor_i <= 1'b0;
    go(lpmc_pkg::M_RUN, 32'hc0, lpmc_pkg::M_RUN);
    ck("bypass", 0, step_down_converter_bypass_o);
    vdd_below_step_down_converter_lvl_i <= 1'b1;
    tk(3);
    ck("bypass", 1, step_down_converter_bypass_o);
    go(lpmc_pkg::M_RUN, 32'h38, lpmc_pkg::M_RUN);
    vdd_below_pvd_i <= 1'b1;
    tk(3);
    ck("pvd_irq", 1, pvd_irq_o);
    vdd_below_pvd_i <= 1'b0;
    wb(1'b0, lpmc_pkg::STAT_OFS, 32'h0);
    ck("pvd_flags", 3, rd[9:8]);
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, busy, vdd_below_bor_i} = '0;
    {vdd_below_pvd_i, vdd_below_step_down_converter_lvl_i, opt_valid_i} = '0;
    {periph_hsi_req_i, wakeup_pin_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {opt_bor_level_i, opt_step_down_converter_level_i} = '0;
    wake_i = '0;
    vdda_ok_i = 1'b1;
    want = lpmc_pkg::M_SHUTDOWN;
    tk(16);
    rst_i <= 1'b0;
    tk(2);
    t_reset;
    t_sleep;
    t_stop;
    t_standby;
    t_supply;
    close_out;
  end
endmodule // tb
